// ===== core/tx_clk_cfg_defs.vh
`ifndef TX_CLK_CFG_DEFS_VH
`define TX_CLK_CFG_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_TX_CLOCK_MULT_CONFIG 8'h86
`define ADDR_TX_LOCK_CONFIG 8'h87
`define ADDR_TX_CALIBRATION_CONFIG 8'h88

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_TX_CLOCK_MULT_CONFIG 8'h40
`define RST_TX_LOCK_CONFIG 8'h80
`define RST_TX_CALIBRATION_CONFIG 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BW_MSB 7
`define BW_LSB 4
`define MODE_MSB 2
`define MODE_LSB 0
`define LK_RSVD_MSB 7
`define LK_RSVD_LSB 5
`define LK_DATA_KEEP 4
`define LK_SRC_OVR 3
`define LK_SRC_SEL 2
`define LK_LTR 1
`define CAL_FORCE 3
`define CAL_VCO_MSB 2
`define CAL_VCO_LSB 1
`define CAL_SOFT_RST 0

// ----------------------------------------------------------------
// field encodings
// ----------------------------------------------------------------
`define BW_180HZ 4'h0
`define BW_1K37HZ 4'h1
`define BW_380KHZ 4'h4
`define MODE_REFLESS 3'h0
`define MODE_SYNC_REF 3'h1
`define MODE_ASYNC_REF 3'h2
`define MODE_LOOP_TIME 3'h6
`define VCO_AUTO 2'h0
`define VCO_SWEEP 2'h1
`define VCO_REF 2'h2
`define VCO_INVALID 2'h3
`define SRC_FREQ 1'b0
`define SRC_SQM 1'b1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define SOFT_RST_NS 400
`define SOFT_RST_CYCLES ((`SOFT_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== core/level_sync.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-stage synchroniser, one chain per bit
// ----------------------------------------------------------------
module level_sync #(
   parameter WIDTH = 4
) (
   input wire i_sys_clk,
   input wire i_reset,
   input wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         reg meta_reg;
         reg sync_reg;
         always @(posedge i_sys_clk) begin
            if (i_reset) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
            end else begin
               meta_reg <= i_async[g];
               sync_reg <= meta_reg;
            end
         end
         assign o_sync[g] = sync_reg;
      end
   endgenerate
endmodule // level_sync

// ===== core/tx_clock_unit_config_regs.v
`timescale 1ns/1ps
`include "tx_clk_cfg_defs.vh"

// Function
// RULE1: bandwidth codes 0000=180 Hz, 0001=1.37 kHz, valid in modes 2 and 6.
// RULE2: code 0100=380 kHz valid in modes 0,1; other codes unsupported.
// RULE3: mode 000 referenceless, 001 sync ref, 010 async ref, 110 loop timing.
// RULE4: mode 001 acts exactly like setting the lock-to-reference bit.
// RULE5: software should use 1.37 kHz bandwidth with loop timing mode.
// RULE6: any change of timing mode starts a transmit recalibration.
// RULE7: software writes 100 into the reserved bits 7:5 of lock config.
// RULE8: with lock to reference, CDR locks to reference unless data-keep bit set.
// RULE9: override 0 picks loss-of-lock source from mode and reports it.
// RULE10: override 1 uses source bit: 0 frequency difference, 1 quality monitor.
// RULE11: lock-to-reference bit 1 locks the multiplier to the reference.
// RULE12: force-recalibrate starts calibration, keeps registers, self-clears when done.
// RULE13: vco code 00 centres on reference if present, else sweeps.
// RULE14: vco code 01 always sweeps the whole range.
// RULE15: vco code 10 always centres on the reference.
// RULE16: vco code 11 invalid; loss-of-lock alarm held on.
// RULE17: software uses vco code 10 or 00 under lineside loopback.
// RULE18: software avoids registers 205, 226 when vco is x0 with reference.
// RULE19: soft reset returns all registers to defaults, then self-clears; the code leaves the force bit as it was.
// RULE20: software forces recalibration after leaving power-down.
// RULE21: busy self-clearing bits read back 1 while in progress.
module tx_clock_unit_config_regs #(
   parameter SOFT_RST_LEN = `SOFT_RST_CYCLES
) (
   input wire i_sys_clk,
   input wire i_reset,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [7:0] i_reg_addr,
   input wire [7:0] i_reg_wdata,
   output reg [7:0] o_reg_rdata,
   output reg o_reg_rvalid,
   input wire i_ref_present,
   input wire i_cal_done,
   input wire i_freq_lock_lost,
   input wire i_sqm_lock_lost,
   output reg [3:0] o_tx_pll_loop_bw,
   output reg o_bw_valid,
   output reg [2:0] o_tx_timing_mode_sel,
   output reg o_lock_to_ref,
   output reg o_cdr_lock_to_ref,
   output reg o_lock_loss_src,
   output reg o_vco_sweep_full,
   output reg o_vco_center_ref,
   output reg o_cal_start,
   output reg o_calibrating,
   output reg o_lock_loss_alarm
);
   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;

   // ----------------------------------------------------------------
   // reset fields
   // ----------------------------------------------------------------
   // sliced here so no reset load truncates a wider constant
   localparam [7:0] MULT_RST = `RST_TX_CLOCK_MULT_CONFIG;
   localparam [7:0] LOCK_RST = `RST_TX_LOCK_CONFIG;
   localparam [7:0] CAL_RST = `RST_TX_CALIBRATION_CONFIG;
   localparam [3:0] BW_RST = MULT_RST[`BW_MSB:`BW_LSB];
   localparam [2:0] MODE_RST = MULT_RST[`MODE_MSB:`MODE_LSB];
   localparam [2:0] RSVD_RST = LOCK_RST[`LK_RSVD_MSB:`LK_RSVD_LSB];
   localparam [1:0] VCO_RST = CAL_RST[`CAL_VCO_MSB:`CAL_VCO_LSB];

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   reg [3:0] tx_pll_loop_bw_reg;
   reg [2:0] tx_timing_mode_sel_reg;
   reg [2:0] lock_rsvd_reg;
   reg cdr_data_lock_keep_reg;
   reg lock_loss_src_override_reg;
   reg lock_loss_src_sel_reg;
   reg ltr_reg;
   reg force_recalibrate_reg;
   reg [1:0] vco_cal_mode_reg;
   reg tx_soft_reset_reg;
   reg [7:0] rst_cnt_reg;
   reg [2:0] mode_prev_reg;
   reg mode_pending_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg done_prev_reg;
   reg force_run_reg;
   reg lock_loss_src_eff;
   reg [7:0] rdata_next;
   wire [3:0] sync_out;
   wire ref_ok;
   wire cal_done_s;
   wire freq_lol_s;
   wire sqm_lol_s;
   wire done_rise;
   wire wr_mult;
   wire wr_lock;
   wire wr_cal;
   wire mode_changed;
   wire cal_req;
   wire lock_ref_eff;
   wire force_wr;

   // ----------------------------------------------------------------
   // analog status crossing
   // ----------------------------------------------------------------
   level_sync #(
      .WIDTH(4)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_async({i_sqm_lock_lost, i_freq_lock_lost, i_cal_done, i_ref_present}),
      .o_sync(sync_out)
   );

   assign ref_ok = sync_out[0];
   assign cal_done_s = sync_out[1];
   assign freq_lol_s = sync_out[2];
   assign sqm_lol_s = sync_out[3];
   assign done_rise = cal_done_s & ~done_prev_reg;

   // writes are ignored while the soft reset sequence is still running
   assign wr_mult = i_reg_wr & ~tx_soft_reset_reg & (i_reg_addr == `ADDR_TX_CLOCK_MULT_CONFIG);
   assign wr_lock = i_reg_wr & ~tx_soft_reset_reg & (i_reg_addr == `ADDR_TX_LOCK_CONFIG);
   assign wr_cal = i_reg_wr & ~tx_soft_reset_reg & (i_reg_addr == `ADDR_TX_CALIBRATION_CONFIG);
   assign force_wr = wr_cal & i_reg_wdata[`CAL_FORCE] & ~i_reg_wdata[`CAL_SOFT_RST];

   assign mode_changed = (mode_prev_reg != tx_timing_mode_sel_reg); // RULE6
   assign cal_req = force_recalibrate_reg | mode_pending_reg | mode_changed;
   assign lock_ref_eff = ltr_reg | (tx_timing_mode_sel_reg == `MODE_SYNC_REF); // RULE4

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         tx_pll_loop_bw_reg <= BW_RST;
         tx_timing_mode_sel_reg <= MODE_RST;
         lock_rsvd_reg <= RSVD_RST;
         cdr_data_lock_keep_reg <= LOCK_RST[`LK_DATA_KEEP];
         lock_loss_src_override_reg <= LOCK_RST[`LK_SRC_OVR];
         lock_loss_src_sel_reg <= LOCK_RST[`LK_SRC_SEL];
         ltr_reg <= LOCK_RST[`LK_LTR];
         vco_cal_mode_reg <= VCO_RST;
         tx_soft_reset_reg <= 1'b0;
         rst_cnt_reg <= 8'h00;
      end else if (tx_soft_reset_reg) begin
         // defaults reloaded at the start; bit stays up until the count ends
         if (rst_cnt_reg == 8'h00) begin
            tx_soft_reset_reg <= 1'b0; // RULE19
         end else begin
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
         end
      end else if (wr_cal && i_reg_wdata[`CAL_SOFT_RST]) begin
         // force bit and a running calibration survive a soft reset
         tx_pll_loop_bw_reg <= BW_RST; // RULE19
         tx_timing_mode_sel_reg <= MODE_RST;
         lock_rsvd_reg <= RSVD_RST;
         cdr_data_lock_keep_reg <= LOCK_RST[`LK_DATA_KEEP];
         lock_loss_src_override_reg <= LOCK_RST[`LK_SRC_OVR];
         lock_loss_src_sel_reg <= LOCK_RST[`LK_SRC_SEL];
         ltr_reg <= LOCK_RST[`LK_LTR];
         vco_cal_mode_reg <= VCO_RST;
         tx_soft_reset_reg <= 1'b1; // RULE21
         rst_cnt_reg <= SOFT_RST_LEN[7:0] - 8'h01;
      end else begin
         if (wr_mult) begin
            tx_pll_loop_bw_reg <= i_reg_wdata[`BW_MSB:`BW_LSB];
            tx_timing_mode_sel_reg <= i_reg_wdata[`MODE_MSB:`MODE_LSB]; // RULE3
         end
         if (wr_lock) begin
            lock_rsvd_reg <= i_reg_wdata[`LK_RSVD_MSB:`LK_RSVD_LSB]; // RULE7
            cdr_data_lock_keep_reg <= i_reg_wdata[`LK_DATA_KEEP];
            lock_loss_src_override_reg <= i_reg_wdata[`LK_SRC_OVR];
            lock_loss_src_sel_reg <= i_reg_wdata[`LK_SRC_SEL];
            ltr_reg <= i_reg_wdata[`LK_LTR];
         end
         if (wr_cal) begin
            vco_cal_mode_reg <= i_reg_wdata[`CAL_VCO_MSB:`CAL_VCO_LSB];
         end
      end
   end

   // ----------------------------------------------------------------
   // recalibration sequencer
   // ----------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cal_req) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (done_rise) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         state_reg <= ST_IDLE;
         force_recalibrate_reg <= 1'b0;
         mode_prev_reg <= MODE_RST;
         force_run_reg <= 1'b0;
         mode_pending_reg <= 1'b0;
         done_prev_reg <= 1'b0;
         o_cal_start <= 1'b0;
         o_calibrating <= 1'b0;
      end else begin
         state_reg <= state_next;
         done_prev_reg <= cal_done_s;
         mode_prev_reg <= tx_timing_mode_sel_reg;
         o_cal_start <= (state_reg == ST_IDLE) && cal_req; // RULE6 RULE12
         o_calibrating <= (state_next == ST_RUN);
         // a mode change seen mid-run queues one more pass
         if (mode_changed && state_reg == ST_RUN) begin
            mode_pending_reg <= 1'b1; // RULE6
         end else if (state_reg == ST_IDLE) begin
            mode_pending_reg <= 1'b0;
         end
         // remember whether the force bit launched this run
         if (state_reg == ST_IDLE && cal_req) begin
            force_run_reg <= force_recalibrate_reg;
         end else if (state_reg == ST_RUN && done_rise) begin
            force_run_reg <= 1'b0;
         end
         // a new write of 1 wins over the completion clear; a force written
         // during another run stays set so that it gets a run of its own
         if (force_wr) begin
            force_recalibrate_reg <= 1'b1; // RULE12 RULE21
         end else if (state_reg == ST_RUN && done_rise && force_run_reg) begin
            force_recalibrate_reg <= 1'b0; // RULE12
         end
      end
   end

   // ----------------------------------------------------------------
   // loss-of-lock source choice
   // ----------------------------------------------------------------
   always @* begin
      if (lock_loss_src_override_reg) begin
         lock_loss_src_eff = lock_loss_src_sel_reg; // RULE10
      end else if (tx_timing_mode_sel_reg == `MODE_REFLESS) begin
         // no reference to compare against, so only the monitor can judge
         lock_loss_src_eff = `SRC_SQM; // RULE9
      end else begin
         lock_loss_src_eff = `SRC_FREQ; // RULE9
      end
   end

   // ----------------------------------------------------------------
   // control outputs
   // ----------------------------------------------------------------
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_tx_pll_loop_bw <= BW_RST;
         o_bw_valid <= 1'b0;
         o_tx_timing_mode_sel <= MODE_RST;
         o_lock_to_ref <= 1'b0;
         o_cdr_lock_to_ref <= 1'b0;
         o_lock_loss_src <= `SRC_SQM;
         o_vco_sweep_full <= 1'b0;
         o_vco_center_ref <= 1'b0;
         o_lock_loss_alarm <= 1'b0;
      end else begin
         o_tx_pll_loop_bw <= tx_pll_loop_bw_reg;
         o_tx_timing_mode_sel <= tx_timing_mode_sel_reg; // RULE3
         case (tx_pll_loop_bw_reg)
            `BW_180HZ, `BW_1K37HZ: begin
               o_bw_valid <= (tx_timing_mode_sel_reg == `MODE_ASYNC_REF)
                  || (tx_timing_mode_sel_reg == `MODE_LOOP_TIME); // RULE1
            end
            `BW_380KHZ: begin
               o_bw_valid <= (tx_timing_mode_sel_reg == `MODE_REFLESS)
                  || (tx_timing_mode_sel_reg == `MODE_SYNC_REF); // RULE2
            end
            default: begin
               o_bw_valid <= 1'b0; // RULE2
            end
         endcase
         o_lock_to_ref <= lock_ref_eff; // RULE11
         o_cdr_lock_to_ref <= lock_ref_eff & ~cdr_data_lock_keep_reg; // RULE8
         o_lock_loss_src <= lock_loss_src_eff;
         o_vco_sweep_full <= (vco_cal_mode_reg == `VCO_SWEEP)
            || (vco_cal_mode_reg == `VCO_AUTO && !ref_ok); // RULE13 RULE14
         o_vco_center_ref <= (vco_cal_mode_reg == `VCO_REF)
            || (vco_cal_mode_reg == `VCO_AUTO && ref_ok); // RULE13 RULE15
         if (vco_cal_mode_reg == `VCO_INVALID) begin
            o_lock_loss_alarm <= 1'b1; // RULE16
         end else if (lock_loss_src_eff == `SRC_SQM) begin
            o_lock_loss_alarm <= sqm_lol_s; // RULE10
         end else begin
            o_lock_loss_alarm <= freq_lol_s; // RULE10
         end
      end
   end

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   always @* begin
      rdata_next = 8'h00;
      case (i_reg_addr)
         `ADDR_TX_CLOCK_MULT_CONFIG: begin
            rdata_next = {tx_pll_loop_bw_reg, 1'b0, tx_timing_mode_sel_reg};
         end
         `ADDR_TX_LOCK_CONFIG: begin
            // source bit shows the automatic choice when not overridden
            rdata_next = {lock_rsvd_reg, cdr_data_lock_keep_reg,
               lock_loss_src_override_reg, lock_loss_src_eff, ltr_reg, 1'b0}; // RULE9
         end
         `ADDR_TX_CALIBRATION_CONFIG: begin
            rdata_next = {4'h0, force_recalibrate_reg, vco_cal_mode_reg,
               tx_soft_reset_reg}; // RULE21
         end
         default: begin
            rdata_next = 8'h00;
         end
      endcase
   end

   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_reg_rdata <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= rdata_next;
         end
      end
   end
endmodule // tx_clock_unit_config_regs

// ===== sim/tx_cfg_asserts.sv
`timescale 1ns/1ps
module tx_cfg_asserts #(
   parameter SOFT_RST_LEN = 4
) (
   input logic i_sys_clk,
   input logic i_reset,
   input logic i_reg_wr,
   input logic [7:0] i_reg_addr,
   input logic [7:0] i_reg_wdata,
   input logic i_cal_done,
   input logic [3:0] o_tx_pll_loop_bw,
   input logic o_bw_valid,
   input logic [2:0] o_tx_timing_mode_sel,
   input logic o_lock_to_ref,
   input logic o_cdr_lock_to_ref,
   input logic o_cal_start,
   input logic o_calibrating,
   input logic o_lock_loss_alarm
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   // bandwidth legality is a pure function of the two visible fields
   wire bw_ok = (o_tx_pll_loop_bw <= 4'h1 && (o_tx_timing_mode_sel == 3'h2
      || o_tx_timing_mode_sel == 3'h6))
      || (o_tx_pll_loop_bw == 4'h4 && o_tx_timing_mode_sel <= 3'h1);
   wire wr86 = i_reg_wr && i_reg_addr == 8'h86;
   wire wr87 = i_reg_wr && i_reg_addr == 8'h87;
   wire wr88 = i_reg_wr && i_reg_addr == 8'h88;
   property p_bw_valid;
      !$past(i_reset) && $stable(o_tx_pll_loop_bw) && $stable(o_tx_timing_mode_sel)
         |-> o_bw_valid == bw_ok;
   endproperty
   a_bw_valid: assert property (p_bw_valid)
      else $error("bandwidth valid flag wrong");
   property p_mode_follows;
      wr86 |-> ##2 o_tx_timing_mode_sel == $past(i_reg_wdata[2:0], 2);
   endproperty
   a_mode_follows: assert property (p_mode_follows)
      else $error("timing mode not taken");
   property p_sync_ref;
      o_tx_timing_mode_sel == 3'h1 |-> o_lock_to_ref;
   endproperty
   a_sync_ref: assert property (p_sync_ref)
      else $error("sync mode without lock to reference");
   property p_mode_recal;
      $changed(o_tx_timing_mode_sel) |-> ##[0:2] o_calibrating;
   endproperty
   a_mode_recal: assert property (p_mode_recal)
      else $error("mode change without recalibration");
   property p_cdr_ref;
      o_cdr_lock_to_ref |-> o_lock_to_ref;
   endproperty
   a_cdr_ref: assert property (p_cdr_ref)
      else $error("cdr on reference without lock to reference");
   property p_ltr_bit;
      wr87 && i_reg_wdata[1] |-> ##2 o_lock_to_ref;
   endproperty
   a_ltr_bit: assert property (p_ltr_bit)
      else $error("lock to reference bit ignored");
   property p_force_start;
      wr88 && i_reg_wdata[3] |-> ##2 o_calibrating;
   endproperty
   a_force_start: assert property (p_force_start)
      else $error("forced recalibration not started");
   property p_cal_end;
      o_calibrating && $rose(i_cal_done) |-> ##[1:6] !o_calibrating;
   endproperty
   a_cal_end: assert property (p_cal_end)
      else $error("calibration did not end");
   property p_vco_invalid;
      wr88 && i_reg_wdata[2:1] == 2'h3 && !i_reg_wdata[0] |-> ##[1:3] o_lock_loss_alarm;
   endproperty
   a_vco_invalid: assert property (p_vco_invalid)
      else $error("invalid vco code without alarm");
   property p_start_pulse;
      o_cal_start |-> o_calibrating ##1 !o_cal_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("calibration start not a single pulse");
endmodule // tx_cfg_asserts

// ===== sim/cal_engine_model.sv
`timescale 1ns/1ps
module cal_engine_model (
   input wire logic i_sys_clk,
   input wire logic i_slow,
   input wire logic i_cal_start,
   output logic o_cal_done
);
   int wait_cnt = 0;
   int hold_cnt = 0;
   // done drops on its own so every run sees a fresh rising edge
   always @(posedge i_sys_clk) begin
      if (i_cal_start) wait_cnt <= i_slow ? 40 : 2;
      else if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
      if (wait_cnt == 1) hold_cnt <= 6;
      else if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
   end
   assign o_cal_done = (hold_cnt != 0);
endmodule // cal_engine_model

// ===== sim/tx_clock_unit_config_regs_tb.sv
`timescale 1ns/1ps
module tx_clock_unit_config_regs_tb;
   logic i_sys_clk = 0, i_reset = 1, wr = 0, rd = 0, ref_p = 0, sqm_l = 0, slow = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00;
   logic freq_l = 0;
   wire [7:0] rdata;
   wire [3:0] bw;
   wire [2:0] mode;
   wire rvalid, bw_valid, ltr, cdr, src, sweep, center, cal_start, calibrating, alarm, cal_done;
   int err_total = 0, num_checks = 0;
   logic [2:0] lk_mode [6] = '{3'h0, 3'h2, 3'h1, 3'h2, 3'h2, 3'h0};
   logic [7:0] lk_val [6] = '{8'h80, 8'h80, 8'h80, 8'h92, 8'h8E, 8'h88};
   logic [3:0] lk_out [6] = '{4'h3, 4'h0, 4'hC, 4'h8, 4'hF, 4'h0};
   logic [7:0] lk_rd [6] = '{8'h84, 8'h80, 8'h80, 8'h92, 8'h8E, 8'h88};
   logic [7:0] bw_val [7] = '{8'h02, 8'h16, 8'h40, 8'h41, 8'h00, 8'h42, 8'h82};
   logic bw_exp [7] = '{1, 1, 1, 1, 0, 0, 0};
   logic [7:0] vc_val [5] = '{8'h00, 8'h00, 8'h02, 8'h04, 8'h06};
   logic vc_ref [5] = '{1, 0, 1, 0, 1};
   logic [2:0] vc_exp [5] = '{3'h2, 3'h4, 3'h4, 3'h2, 3'h1};
   logic [2:0] vc_msk [5] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h1};
   initial forever #50 i_sys_clk = ~i_sys_clk;
   tx_clock_unit_config_regs #(.SOFT_RST_LEN(4)) uut (.i_sys_clk(i_sys_clk),
      .i_reset(i_reset), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_ref_present(ref_p), .i_cal_done(cal_done), .i_freq_lock_lost(freq_l),
      .i_sqm_lock_lost(sqm_l), .o_tx_pll_loop_bw(bw), .o_bw_valid(bw_valid),
      .o_tx_timing_mode_sel(mode), .o_lock_to_ref(ltr), .o_cdr_lock_to_ref(cdr),
      .o_lock_loss_src(src), .o_vco_sweep_full(sweep), .o_vco_center_ref(center),
      .o_cal_start(cal_start), .o_calibrating(calibrating), .o_lock_loss_alarm(alarm));
   cal_engine_model cal_eng (.i_sys_clk(i_sys_clk), .i_slow(slow),
      .i_cal_start(cal_start), .o_cal_done(cal_done));
   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk) #1;
      wr = 1; addr = a; wdata = d;
      @(posedge i_sys_clk) #1;
      wr = 0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_sys_clk) #1;
      rd = 1; addr = a;
      @(posedge i_sys_clk) #1;
      rd = 0;
      chk({7'h00, rvalid}, 8'h01);
      chk(rdata, exp);
   endtask
   task automatic settle();
      repeat (3) @(posedge i_sys_clk);
      #1;
   endtask
   // bounded, a stuck calibration must not hang the run
   task automatic wait_idle();
      int n;
      n = 0;
      settle();
      while (calibrating !== 1'b0 && n < 500) begin
         @(posedge i_sys_clk) #1;
         n++;
      end
      chk({7'h00, calibrating}, 8'h00);
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge i_sys_clk);
      #1 i_reset = 0;
      rd_reg(8'h86, 8'h40);
      rd_reg(8'h87, 8'h84);
      rd_reg(8'h88, 8'h00);
      wr_reg(8'h89, 8'hFF);
      rd_reg(8'h89, 8'h00);
      wr_reg(8'h86, 8'hFF);
      wait_idle();
      rd_reg(8'h86, 8'hF7);
      for (int i = 0; i < 7; i++) begin
         wr_reg(8'h86, bw_val[i]);
         wait_idle();
         chk({bw, 1'b0, mode}, bw_val[i]);
         chk({7'h00, bw_valid}, {7'h00, bw_exp[i]});
      end
      sqm_l = 1;
      for (int i = 0; i < 6; i++) begin
         wr_reg(8'h86, {4'h4, 1'b0, lk_mode[i]});
         wait_idle();
         wr_reg(8'h87, lk_val[i]);
         settle();
         chk({4'h0, ltr, cdr, src, alarm}, {4'h0, lk_out[i]});
         rd_reg(8'h87, lk_rd[i]);
      end
      freq_l = 1;
      settle();
      chk({7'h00, alarm}, 8'h01);
      freq_l = 0;
      for (int i = 0; i < 5; i++) begin
         ref_p = vc_ref[i];
         wr_reg(8'h88, vc_val[i]);
         settle();
         chk({5'h00, {sweep, center, alarm} & vc_msk[i]}, {5'h00, vc_exp[i]});
         rd_reg(8'h88, vc_val[i]);
      end
      slow = 1;
      wr_reg(8'h88, 8'h08);
      rd_reg(8'h88, 8'h08);
      chk({7'h00, calibrating}, 8'h01);
      wait_idle();
      rd_reg(8'h88, 8'h00);
      rd_reg(8'h86, 8'h40);
      rd_reg(8'h87, 8'h88);
      slow = 0;
      wr_reg(8'h86, 8'h12);
      wait_idle();
      wr_reg(8'h88, 8'h01);
      rd_reg(8'h88, 8'h01);
      wait_idle();
      rd_reg(8'h86, 8'h40);
      rd_reg(8'h87, 8'h84);
      rd_reg(8'h88, 8'h00);
      rd_reg(8'h85, 8'h00);
      summarize();
   end
   initial begin
      #(100 * 20000);
      err_total++;
      summarize();
   end
endmodule // tx_clock_unit_config_regs_tb
bind tx_clock_unit_config_regs tx_cfg_asserts #(.SOFT_RST_LEN(SOFT_RST_LEN)) chk_i (
   .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg_wr(i_reg_wr),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_cal_done(i_cal_done),
   .o_tx_pll_loop_bw(o_tx_pll_loop_bw), .o_bw_valid(o_bw_valid),
   .o_tx_timing_mode_sel(o_tx_timing_mode_sel), .o_lock_to_ref(o_lock_to_ref),
   .o_cdr_lock_to_ref(o_cdr_lock_to_ref), .o_cal_start(o_cal_start),
   .o_calibrating(o_calibrating), .o_lock_loss_alarm(o_lock_loss_alarm));
